/* src/lcd_host_port_regs.vh */
// Constants of the host port: command indices, field positions, address windows
`ifndef LCD_HOST_PORT_REGS_VH
`define LCD_HOST_PORT_REGS_VH
`define IDX_X_ADDR 4'h0
`define IDX_READ_SEL 4'h1
`define IDX_Y_LOW 4'h2
`define IDX_Y_HIGH 4'h3
`define IDX_DISP_MODE 4'h4
`define IDX_POWER 4'h5
`define IDX_POWER3 4'hE
`define BIT_GRAPHIC_ON 0
`define BIT_SEGMENT_ON 1
`define BIT_ICON_ON 2
`define BIT_STANDBY 0
`define BIT_SLEEP 1
`define BIT_EXT_CLOCK 0
`define X_GRAPHIC_MAX 4'hF
`define X_SEGMENT_MAX 4'h1
`define Y_GRAPHIC_MAX 7'h3F
`define Y_SEGMENT_MIN 7'h40
`define Y_SEGMENT_MAX 7'h42
`define REG_RESET_VALUE 4'h0
`define FIFO_WIDTH 9
`define FIFO_DEPTH 4
`define SERIAL_LAST_BIT 3'h7
`endif

/* src/write_fifo.v */
// Small flip-flop FIFO holding written bytes until they are applied
`timescale 1ns/1ns
`default_nettype none
module write_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4
) (
  input wire ref_clk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = (DEPTH <= 2) ? 1 : (DEPTH <= 4) ? 2 : (DEPTH <= 8) ? 3 : 4;
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
  // Storage needs no reset; it is only read where count says it holds data
  always @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule // write_fifo
`default_nettype wire

/* src/lcd_driver_host_interface.v */
// Host access port of the LCD driver: parallel 80/68 bus, serial shifter, command file
`timescale 1ns/1ns
`default_nettype none
`include "lcd_host_port_regs.vh"
module lcd_driver_host_interface (
  input wire ref_clk,
  input wire reset,
  input wire reset_n,
  input wire parallel_select,
  input wire bus_family_select,
  input wire chip_select_n,
  input wire register_select,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire [7:0] data_in,
  output wire [7:0] data_out,
  output wire data_oe,
  input wire serial_clock,
  input wire serial_data,
  input wire aux_display_clock,
  output wire host_busy,
  output reg ram_we,
  output reg [3:0] ram_addr_x,
  output reg [6:0] ram_addr_y,
  output reg [7:0] ram_wdata,
  output wire ram_segment_region,
  input wire [7:0] ram_rdata,
  input wire ram_ready,
  output wire graphic_enable,
  output wire segment_enable,
  output wire icon_enable,
  output wire power_circuit_on,
  output wire graphic_outputs_ground,
  output wire aux_clock_external,
  output reg aux_clock_tick
);
  localparam ST_IDLE = 3'b001;
  localparam ST_INC = 3'b010;
  localparam ST_LOAD = 3'b100;
  localparam NPIN = 18;

  function readable_index;
    input [3:0] idx;
    begin
      readable_index = (idx != `IDX_READ_SEL) && (idx != 4'hF);
    end
  endfunction

  function in_segment_rows;
    input [6:0] y;
    begin
      in_segment_rows = (y >= `Y_SEGMENT_MIN);
    end
  endfunction

  function [3:0] next_x;
    input [3:0] x;
    input [6:0] y;
    begin
      if (in_segment_rows(y)) begin
        next_x = (x >= `X_SEGMENT_MAX) ? 4'h0 : x + 4'h1;
      end else begin
        next_x = (x == `X_GRAPHIC_MAX) ? 4'h0 : x + 4'h1;
      end
    end
  endfunction

  // Read condition of either bus family, decoded for the current and the previous sample
  function read_cond;
    input par;
    input csn;
    input fam68;
    input rdn;
    input wrn;
    begin
      read_cond = par & ~csn & (fam68 ? (rdn & wrn) : (~rdn & wrn));
    end
  endfunction

  // Two-stage synchroniser for every pin; third stage only for edge detection
  wire [NPIN-1:0] pins;
  reg [NPIN-1:0] pin_s1_r;
  reg [NPIN-1:0] pin_s2_r;
  reg [NPIN-1:0] pin_s3_r;
  assign pins = {
    reset_n,
    parallel_select,
    bus_family_select,
    chip_select_n,
    register_select,
    read_strobe_n,
    write_strobe_n,
    serial_clock,
    serial_data,
    aux_display_clock,
    data_in
  };
  always @(posedge ref_clk) begin
    if (reset) begin
      pin_s1_r <= {NPIN{1'b0}};
      pin_s2_r <= {NPIN{1'b0}};
      pin_s3_r <= {NPIN{1'b0}};
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  wire rst;
  wire par_mode;
  wire family_68;
  wire cs_n;
  wire rs;
  wire rd_n;
  wire wr_n;
  wire sclk;
  wire sdat;
  wire [7:0] dbus;
  assign rst = reset | ~pin_s2_r[17];
  assign par_mode = pin_s2_r[16];
  assign family_68 = pin_s2_r[15];
  assign cs_n = pin_s2_r[14];
  assign rs = pin_s2_r[13];
  assign rd_n = pin_s2_r[12];
  assign wr_n = pin_s2_r[11];
  assign sclk = pin_s2_r[10];
  assign sdat = pin_s2_r[9];
  assign dbus = pin_s2_r[7:0];

  // Bus family decode; in 68 style the read pin is the enable, the write pin is R/W
  wire rd_active;
  wire rd_active_prev;
  wire wr_event;
  wire rd_start;
  assign rd_active = read_cond(par_mode, cs_n, family_68, rd_n, wr_n);
  assign rd_active_prev = read_cond(pin_s3_r[16], pin_s3_r[14], pin_s3_r[15], pin_s3_r[12],
    pin_s3_r[11]);
  assign rd_start = rd_active & ~rd_active_prev;
  // Edge taken from stage 3 to 2; data is synchronised alongside so it is stable here
  wire wr_rise_80;
  wire e_fall_68;
  assign wr_rise_80 = ~pin_s3_r[11] & wr_n & rd_n;
  assign e_fall_68 = pin_s3_r[12] & ~rd_n & ~wr_n;
  assign wr_event = par_mode & ~cs_n & (family_68 ? e_fall_68 : wr_rise_80);

  // Serial shifter, held clear whenever chip select is high
  reg [7:0] shift_r;
  reg [2:0] bit_cnt_r;
  wire sclk_rise;
  wire ser_event;
  assign sclk_rise = sclk & ~pin_s3_r[10];
  assign ser_event = ~par_mode & ~cs_n & sclk_rise & (bit_cnt_r == `SERIAL_LAST_BIT);
  always @(posedge ref_clk) begin
    if (rst || cs_n || par_mode) begin
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[6:0], sdat};
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // Written bytes tagged with register select go through the holding FIFO
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [8:0] fifo_in_data;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [8:0] fifo_out_data;
  reg [2:0] state_r;
  assign fifo_in_valid = wr_event | ser_event;
  assign fifo_in_data = par_mode ? {rs, dbus} : {rs, shift_r[6:0], sdat};
  assign host_busy = ~fifo_in_ready;
  // Draining pauses while a read fetch runs or the RAM side stalls
  assign fifo_out_ready = (state_r == ST_IDLE) & ram_ready & ~rd_start;

  write_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_hold (
    .ref_clk(ref_clk),
    .reset(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Command registers: upper nibble is the index, lower nibble the value
  reg [3:0] cmd_r [0:15];
  reg [7:0] rd_latch_r;
  reg [7:0] data_out_r;
  reg dummy_pending_r;
  wire apply;
  wire [3:0] cmd_idx;
  wire [3:0] cmd_val;
  wire [6:0] y_cand;
  wire [3:0] sel;
  assign apply = fifo_out_valid & fifo_out_ready;
  assign cmd_idx = fifo_out_data[7:4];
  assign cmd_val = fifo_out_data[3:0];
  assign y_cand = {cmd_val[2:0], cmd_r[`IDX_Y_LOW]};
  assign sel = cmd_r[`IDX_READ_SEL];

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_cmd
      always @(posedge ref_clk) begin
        if (rst) begin
          cmd_r[gi] <= `REG_RESET_VALUE;
        end else if (apply && fifo_out_data[8] && cmd_idx == gi) begin
          cmd_r[gi] <= cmd_val;
        end
      end
    end
  endgenerate

  // Address counters, RAM write path and read pipeline
  always @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ram_we <= 1'b0;
      ram_addr_x <= 4'h0;
      ram_addr_y <= 7'h00;
      ram_wdata <= 8'h00;
      rd_latch_r <= 8'h00;
      data_out_r <= 8'h00;
      dummy_pending_r <= 1'b1;
    end else begin
      ram_we <= 1'b0;
      if (rd_start) begin
        if (rs) begin
          data_out_r <= readable_index(sel) ? {4'h0, cmd_r[sel]} : 8'h00;
        end else begin
          data_out_r <= rd_latch_r;
          // A write still owing its address step keeps it, so later writes do not overlap
          if (state_r == ST_INC) begin
            ram_addr_x <= next_x(ram_addr_x, ram_addr_y);
          end
          // A dummy read refills the pipeline without moving the address
          state_r <= dummy_pending_r ? ST_LOAD : ST_INC;
          dummy_pending_r <= 1'b0;
        end
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (apply) begin
              if (!fifo_out_data[8]) begin
                ram_we <= 1'b1;
                ram_wdata <= fifo_out_data[7:0];
                state_r <= ST_INC;
                dummy_pending_r <= 1'b1;
              end else if (cmd_idx == `IDX_X_ADDR) begin
                if (!in_segment_rows(ram_addr_y) || cmd_val <= `X_SEGMENT_MAX) begin
                  ram_addr_x <= cmd_val;
                end
                dummy_pending_r <= 1'b1;
              end else if (cmd_idx == `IDX_Y_HIGH) begin
                if (y_cand <= `Y_SEGMENT_MAX) begin
                  ram_addr_y <= y_cand;
                  if (in_segment_rows(y_cand) && ram_addr_x > `X_SEGMENT_MAX) begin
                    ram_addr_x <= 4'h0;
                  end
                end
                dummy_pending_r <= 1'b1;
              end
            end
          end
          ST_INC: begin
            ram_addr_x <= next_x(ram_addr_x, ram_addr_y);
            state_r <= ST_LOAD;
          end
          ST_LOAD: begin
            rd_latch_r <= ram_rdata;
            state_r <= ST_IDLE;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // A write leaves the state in ST_INC then ST_LOAD, so its latch holds the next byte
  // only after the address moved; the dummy flag still forces one refill read

  assign ram_segment_region = in_segment_rows(ram_addr_y);
  // Serial mode never enables the driver, so nothing is ever read back serially
  assign data_oe = rd_active;
  assign data_out = data_out_r;

  wire low_power;
  assign low_power = cmd_r[`IDX_POWER][`BIT_STANDBY] | cmd_r[`IDX_POWER][`BIT_SLEEP];
  assign graphic_enable = cmd_r[`IDX_DISP_MODE][`BIT_GRAPHIC_ON] & ~low_power;
  assign segment_enable = cmd_r[`IDX_DISP_MODE][`BIT_SEGMENT_ON];
  assign icon_enable = cmd_r[`IDX_DISP_MODE][`BIT_ICON_ON];
  assign power_circuit_on = ~low_power;
  assign graphic_outputs_ground = low_power;
  assign aux_clock_external = cmd_r[`IDX_POWER3][`BIT_EXT_CLOCK];

  // External display clock edges for segment and icon timing when the flag is set
  // The tick is a one-cycle enable; the slow clock itself never clocks any flop
  wire aux_rise;
  assign aux_rise = pin_s2_r[8] & ~pin_s3_r[8];
  always @(posedge ref_clk) begin
    if (rst) begin
      aux_clock_tick <= 1'b0;
    end else begin
      aux_clock_tick <= aux_clock_external & aux_rise;
    end
  end
endmodule // lcd_driver_host_interface
`default_nettype wire

/* verification/host_port_checker.sv */
// Port checker for the LCD host port
`timescale 1ns/1ns
`default_nettype none
module host_port_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic reset_n,
  input wire logic parallel_select,
  input wire logic chip_select_n,
  input wire logic data_oe,
  input wire logic ram_we,
  input wire logic ram_ready,
  input wire logic [3:0] ram_addr_x,
  input wire logic ram_segment_region,
  input wire logic graphic_enable,
  input wire logic power_circuit_on,
  input wire logic graphic_outputs_ground,
  input wire logic aux_clock_external,
  input wire logic aux_clock_tick
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // Four samples cover the two-stage pin synchroniser
  chk_bus_deselect: assert property (chip_select_n [*4] |-> !data_oe)
    else $error("data bus driven while deselected");
  chk_serial_noread: assert property ((!parallel_select) [*4] |-> !data_oe)
    else $error("data bus driven in serial mode");
  chk_write_pulse: assert property (ram_we |=> !ram_we)
    else $error("ram write longer than one cycle");
  chk_stall_hold: assert property ((!ram_ready) [*3] |-> !ram_we)
    else $error("ram write while stalled");
  chk_ground_power: assert property (graphic_outputs_ground |->
    !power_circuit_on && !graphic_enable) else $error("power or graphic on while grounded");
  chk_segment_x: assert property (ram_we && ram_segment_region |-> ram_addr_x <= 4'h1)
    else $error("segment write outside its columns");
  chk_tick_gate: assert property ((!aux_clock_external) [*2] |-> !aux_clock_tick)
    else $error("aux tick without external clock flag");
  chk_pin_reset: assert property ((!reset_n) [*5] |->
    !ram_we && !graphic_enable && power_circuit_on) else $error("reset pin not applied");
  cover property (ram_we && ram_segment_region);
  cover property (aux_clock_tick);
  cover property (data_oe);
  cover property (graphic_outputs_ground);
endmodule // host_port_checker
bind lcd_driver_host_interface host_port_checker u_checker (
  .ref_clk(ref_clk), .reset(reset), .reset_n(reset_n), .parallel_select(parallel_select),
  .chip_select_n(chip_select_n), .data_oe(data_oe), .ram_we(ram_we), .ram_ready(ram_ready),
  .ram_addr_x(ram_addr_x), .ram_segment_region(ram_segment_region),
  .graphic_enable(graphic_enable), .power_circuit_on(power_circuit_on),
  .graphic_outputs_ground(graphic_outputs_ground),
  .aux_clock_external(aux_clock_external), .aux_clock_tick(aux_clock_tick)
);
`default_nettype wire

/* verification/mpu_model.sv */
// Host processor model for the parallel bus and the serial shifter
`timescale 1ns/1ns
`default_nettype none
module mpu_model (
  input wire logic ref_clk,
  input wire logic fam,
  input wire logic [7:0] data_out,
  output var logic chip_select_n,
  output var logic register_select,
  output var logic read_strobe_n,
  output var logic write_strobe_n,
  output var logic [7:0] data_in,
  output var logic serial_clock,
  output var logic serial_data
);
  initial begin
    chip_select_n = 1'b1;
    register_select = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    data_in = 8'h00;
    serial_clock = 1'b0;
    serial_data = 1'b0;
  end
  // In 68 style read_strobe_n carries E and write_strobe_n carries R/W
  task automatic xfer(input logic cs_i, input logic rs_i, input logic rd_i,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    chip_select_n <= cs_i;
    register_select <= rs_i;
    data_in <= d;
    read_strobe_n <= fam | !rd_i;
    write_strobe_n <= rd_i;
    repeat (6) @(posedge ref_clk);
    q = data_out;
    read_strobe_n <= !fam;
    // R/W must outlast the falling E, so it returns high only later
    write_strobe_n <= rd_i | !fam;
    repeat (4) @(posedge ref_clk);
    write_strobe_n <= 1'b1;
    chip_select_n <= 1'b1;
    data_in <= ~d;
    repeat (4) @(posedge ref_clk);
  endtask
  // Fewer than eight bits models an aborted frame
  task automatic ser(input logic rs_i, input logic [7:0] d, input int n);
    @(posedge ref_clk);
    chip_select_n <= 1'b0;
    register_select <= rs_i;
    for (int i = 0; i < n; i++) begin
      serial_data <= d[7 - i];
      repeat (4) @(posedge ref_clk);
      serial_clock <= 1'b1;
      repeat (4) @(posedge ref_clk);
      serial_clock <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    chip_select_n <= 1'b1;
    serial_data <= ~serial_data;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule // mpu_model
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the LCD host port
`timescale 1ns/1ns
`default_nettype none
`define CHECK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reset_n = 1'b1;
  logic par = 1'b1;
  logic fam = 1'b0;
  logic ram_ready = 1'b1;
  logic aux = 1'b0;
  logic [2:0] acnt = 3'h0;
  logic cs_n, rs, rd_n, wr_n, sclk, sdat, oe, busy, we, seg, g_en, s_en, i_en, pwr, gnd, ext, tick;
  logic [7:0] din, dout, wdata, q, d0, d1, d2;
  logic [3:0] ax;
  logic [6:0] ay;
  logic [18:0] e;
  logic [7:0] mem [0:2047];
  logic [18:0] exp_q [$];
  logic [3:0] sel [3] = '{4'h1, 4'hE, 4'h4};
  logic [7:0] rexp [3] = '{8'h00, 8'h01, 8'h05};
  int bad_count = 0;
  int total_checks = 0;
  int ticks = 0;
  int oe_serial = 0;
  int t0;
  wire [7:0] ram_rdata;
  assign ram_rdata = mem[{ax, ay}];
  initial forever #2 ref_clk = ~ref_clk;
  // Slow free-running display clock for the external tick path
  always @(posedge ref_clk) begin
    acnt <= acnt + 3'h1;
    if (acnt == 3'h7) aux <= ~aux;
  end
  lcd_driver_host_interface dut (
    .ref_clk(ref_clk), .reset(reset), .reset_n(reset_n), .parallel_select(par),
    .bus_family_select(fam), .chip_select_n(cs_n), .register_select(rs),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_in(din), .data_out(dout),
    .data_oe(oe), .serial_clock(sclk), .serial_data(sdat), .aux_display_clock(aux),
    .host_busy(busy), .ram_we(we), .ram_addr_x(ax), .ram_addr_y(ay), .ram_wdata(wdata),
    .ram_segment_region(seg), .ram_rdata(ram_rdata), .ram_ready(ram_ready),
    .graphic_enable(g_en), .segment_enable(s_en), .icon_enable(i_en),
    .power_circuit_on(pwr), .graphic_outputs_ground(gnd), .aux_clock_external(ext),
    .aux_clock_tick(tick)
  );
  mpu_model mpu (
    .ref_clk(ref_clk), .fam(fam), .data_out(dout), .chip_select_n(cs_n),
    .register_select(rs), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_in(din),
    .serial_clock(sclk), .serial_data(sdat)
  );
  // An unexpected write meets an impossible note and is flagged
  always @(posedge ref_clk) begin
    if (we) begin
      mem[{ax, ay}] = wdata;
      e = exp_q.size() ? exp_q.pop_front() : 19'h7FFFF;
      `CHECK({ax, ay, wdata}, e)
    end
  end
  always @(posedge ref_clk) begin
    if (tick) ticks <= ticks + 1;
    if (oe && !par) oe_serial <= oe_serial + 1;
  end
  task automatic cmd(input logic [7:0] c);
    mpu.xfer(1'b0, 1'b1, 1'b0, c, q);
  endtask
  task automatic rd(input logic rs_i);
    mpu.xfer(1'b0, rs_i, 1'b1, 8'h00, q);
  endtask
  task automatic wr(input logic [3:0] ex, input logic [6:0] ey, input logic [7:0] d);
    exp_q.push_back({ex, ey, d});
    mpu.xfer(1'b0, 1'b0, 1'b0, d, q);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hC434F04D));
    d0 = $urandom;
    d1 = $urandom;
    d2 = $urandom;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHECK({pwr, g_en, s_en, i_en, oe}, 5'h10)
    cmd(8'h25);
    cmd(8'h30);
    cmd(8'h03);
    wr(4'h3, 7'h05, d0);
    wr(4'h4, 7'h05, d1);
    wr(4'h5, 7'h05, d2);
    cmd(8'h03);
    rd(1'b0);
    rd(1'b0);
    `CHECK(q, d0)
    wr(4'h4, 7'h05, d1 ^ 8'h5A);
    rd(1'b0);
    rd(1'b0);
    `CHECK(q, d2)
    for (int i = 0; i < 3; i++) begin
      cmd(8'h40 | (8'h01 << i));
      `CHECK({i_en, s_en, g_en}, 3'h1 << i)
    end
    cmd(8'h45);
    cmd(8'hE1);
    `CHECK(ext, 1'b1)
    t0 = ticks;
    repeat (128) @(posedge ref_clk);
    `CHECK(ticks - t0, 8)
    foreach (sel[k]) begin
      cmd(8'h10 | {4'h0, sel[k]});
      rd(1'b1);
      `CHECK(q, rexp[k])
    end
    for (int i = 1; i < 3; i++) begin
      cmd(8'h50 | i[7:0]);
      `CHECK({gnd, pwr, g_en}, 3'h4)
    end
    cmd(8'h50);
    mpu.xfer(1'b1, 1'b0, 1'b0, 8'hA5, q);
    fam <= 1'b1;
    cmd(8'h0F);
    wr(4'hF, 7'h05, d0);
    wr(4'h0, 7'h05, d1);
    rd(1'b1);
    `CHECK(q, 8'h05)
    cmd(8'h20);
    cmd(8'h34);
    `CHECK(seg, 1'b1)
    cmd(8'h01);
    wr(4'h1, 7'h40, d2);
    wr(4'h0, 7'h40, d0);
    cmd(8'h23);
    cmd(8'h34);
    wr(4'h1, 7'h40, d1);
    // Stalled RAM side lets the holding FIFO fill and refuse
    ram_ready <= 1'b0;
    for (int i = 0; i < 4; i++) wr(i[3:0] & 4'h1, 7'h40, d0 ^ i[7:0]);
    `CHECK(busy, 1'b1)
    mpu.xfer(1'b0, 1'b0, 1'b0, 8'h3C, q);
    ram_ready <= 1'b1;
    repeat (60) @(posedge ref_clk);
    `CHECK(exp_q.size(), 0)
    par <= 1'b0;
    mpu.ser(1'b1, 8'h47, 8);
    `CHECK({i_en, s_en, g_en}, 3'h7)
    mpu.ser(1'b1, 8'h00, 8);
    mpu.ser(1'b0, 8'hFF, 3);
    exp_q.push_back({4'h0, 7'h40, d2});
    mpu.ser(1'b0, d2, 8);
    rd(1'b0);
    `CHECK(oe_serial, 0)
    reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHECK({pwr, g_en, s_en, i_en, ext}, 5'h10)
    reset_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    `CHECK(exp_q.size(), 0)
    stop_test();
  end
endmodule // testbench
`default_nettype wire
